// ==== inc/cssr_map.svh ====
// constants for the cpu status and save register block
// assumes a 5-bit system register number and 32-bit data
`ifndef CSSR_MAP_SVH
`define CSSR_MAP_SVH
`define CSSR_SREG_CAUSE      5'h04
`define CSSR_SREG_STATUS     5'h05
`define CSSR_SREG_TC_PC      5'h10
`define CSSR_SREG_TC_STAT    5'h11
`define CSSR_SREG_DBG_PC     5'h12
`define CSSR_SREG_DBG_STAT   5'h13
`define CSSR_BIT_NONMASK     7
`define CSSR_BIT_FAULT       6
`define CSSR_BIT_IRQ_BLOCK   5
`define CSSR_BIT_CLAMP       4
`define CSSR_BIT_CARRY       3
`define CSSR_BIT_WRAP        2
`define CSSR_BIT_SIGN        1
`define CSSR_BIT_ZERO        0
`define CSSR_STATUS_RESET    8'h20
`define CSSR_STATUS_W        8
`define CSSR_PC_W            26
`define CSSR_SAT_POS         32'h7FFFFFFF
`define CSSR_SAT_NEG         32'h80000000
`endif

// ==== inc/cssr_pkg.sv ====
// types for the cpu status and save register block
// assumes cssr_map.svh constants
package cssr_pkg;
	typedef enum logic [1:0] {
		cssr_op_none,
		cssr_op_plain,
		cssr_op_sat
	} cssr_op_t;
endpackage : cssr_pkg

// ==== hdl/cssr_regs.sv ====
// cpu status word, cause register and save registers
// assumes the pipeline presents one event per cycle, all synchronous to ref_clk_in
`timescale 1ns/1ps
`include "cssr_map.svh"
module cssr_regs (
	input  wire logic             ref_clk_in,
	input  wire logic             reset_n_in,
	input  wire logic             sysreg_write_instr_in,
	input  wire logic             sysreg_read_instr_in,
	input  wire logic [4:0]       sysreg_num_in,
	input  wire logic [31:0]      sysreg_wdata_in,
	input  wire cssr_pkg::cssr_op_t alu_op_in,
	input  wire logic [31:0]      alu_result_in,
	input  wire logic             alu_carry_in,
	input  wire logic             alu_ovf_in,
	input  wire logic             alu_ovf_positive_in,
	input  wire logic             irq_req_in,
	input  wire logic             nmi_req_in,
	input  wire logic             exc_event_in,
	input  wire logic [31:0]      event_code_in,
	input  wire logic             table_call_instr_in,
	input  wire logic             debug_trap_instr_in,
	input  wire logic             illegal_opcode_in,
	input  wire logic             debug_return_instr_in,
	input  wire logic [31:0]      next_pc_in,
	output logic [31:0]           sysreg_rdata_out,
	output logic                  irq_ack_out,
	output logic                  nmi_ack_out,
	output logic [31:0]           sat_result_out,
	output logic                  pc_load_out,
	output logic [31:0]           pc_value_out,
	output logic [31:0]           status_word_out
);
	logic [31:0]                  exception_cause_r;
	logic [`CSSR_STATUS_W-1:0]    status_word_r;
	logic [`CSSR_STATUS_W-1:0]    status_flags_nxt;
	logic [`CSSR_STATUS_W-1:0]    status_word_nxt;
	logic [`CSSR_PC_W-1:0]        table_call_saved_pc_r;
	logic [`CSSR_STATUS_W-1:0]    table_call_saved_status_r;
	logic [`CSSR_PC_W-1:0]        debug_trap_saved_pc_r;
	logic [`CSSR_STATUS_W-1:0]    debug_trap_saved_status_r;
	logic                         debug_window_r;
	logic                         status_wr;
	logic                         tc_pc_wr;
	logic                         tc_status_wr;
	logic                         dbg_pc_wr;
	logic                         dbg_status_wr;
	logic                         dbg_acc;
	logic                         dbg_open;
	logic                         trap_event;
	logic                         cause_load;
	logic                         irq_take;
	logic                         nmi_take;
	logic [31:0]                  sat_val;
	logic [31:0]                  rdata_nxt;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [`CSSR_PC_W-1:0] pc_trim(input logic [31:0] v);
		pc_trim = {v[`CSSR_PC_W-1:1], 1'b0};
	endfunction : pc_trim

	function automatic logic [31:0] pc_wide(input logic [`CSSR_PC_W-1:0] v);
		pc_wide = {{(32-`CSSR_PC_W){1'b0}}, v};
	endfunction : pc_wide

	function automatic logic [31:0] stat_wide(input logic [`CSSR_STATUS_W-1:0] v);
		stat_wide = {{(32-`CSSR_STATUS_W){1'b0}}, v};
	endfunction : stat_wide

	function automatic logic sreg_hit(input logic [4:0] num, input logic [4:0] code);
		sreg_hit = (num == code);
	endfunction : sreg_hit

	// zero test shared by the plain and the clamped flag paths
	function automatic logic is_zero(input logic [31:0] v);
		is_zero = (v == 32'h00000000);
	endfunction : is_zero

	// ---------------------------------------------------------------
	// register write enables
	// ---------------------------------------------------------------
	assign status_wr     = sysreg_write_instr_in && sreg_hit(sysreg_num_in, `CSSR_SREG_STATUS);
	assign tc_pc_wr      = sysreg_write_instr_in && sreg_hit(sysreg_num_in, `CSSR_SREG_TC_PC);
	assign tc_status_wr  = sysreg_write_instr_in && sreg_hit(sysreg_num_in, `CSSR_SREG_TC_STAT);
	// the debug pair only takes writes while its window is open
	assign dbg_pc_wr     = sysreg_write_instr_in && dbg_acc
		&& sreg_hit(sysreg_num_in, `CSSR_SREG_DBG_PC);
	assign dbg_status_wr = sysreg_write_instr_in && dbg_acc
		&& sreg_hit(sysreg_num_in, `CSSR_SREG_DBG_STAT);
	// no enable exists for the cause number

	// ---------------------------------------------------------------
	// trap events
	// ---------------------------------------------------------------
	// plain exceptions save state but do not open the debug window
	assign trap_event = exc_event_in || debug_trap_instr_in || illegal_opcode_in;
	assign dbg_open   = debug_trap_instr_in || illegal_opcode_in;
	assign dbg_acc    = debug_window_r;

	// ---------------------------------------------------------------
	// interrupt acknowledge gating
	// ---------------------------------------------------------------
	// gating uses the registered flags, so a write lands before it can unmask
	assign nmi_take   = nmi_req_in && !status_wr
		&& !status_word_r[`CSSR_BIT_NONMASK];
	assign irq_take   = irq_req_in && !nmi_take && !status_wr
		&& !status_word_r[`CSSR_BIT_IRQ_BLOCK]
		&& !status_word_r[`CSSR_BIT_NONMASK];
	assign cause_load = nmi_take || irq_take || exc_event_in;

	// ---------------------------------------------------------------
	// saturation clamp
	// ---------------------------------------------------------------
	always_comb begin
		if (alu_ovf_in) begin
			sat_val = alu_ovf_positive_in ? `CSSR_SAT_POS : `CSSR_SAT_NEG;
		end else begin
			sat_val = alu_result_in;
		end
	end

	// ---------------------------------------------------------------
	// arithmetic flag update
	// ---------------------------------------------------------------
	always_comb begin
		status_flags_nxt = status_word_r;
		unique case (alu_op_in)
			cssr_pkg::cssr_op_none: begin
			end
			cssr_pkg::cssr_op_plain: begin
				status_flags_nxt[`CSSR_BIT_CARRY] = alu_carry_in;
				status_flags_nxt[`CSSR_BIT_WRAP]  = alu_ovf_in;
				status_flags_nxt[`CSSR_BIT_SIGN]  = alu_result_in[31];
				status_flags_nxt[`CSSR_BIT_ZERO]  = is_zero(alu_result_in);
			end
			cssr_pkg::cssr_op_sat: begin
				status_flags_nxt[`CSSR_BIT_CARRY] = alu_carry_in;
				status_flags_nxt[`CSSR_BIT_WRAP]  = alu_ovf_in;
				status_flags_nxt[`CSSR_BIT_SIGN]  = sat_val[31];
				status_flags_nxt[`CSSR_BIT_ZERO]  = is_zero(sat_val);
				// arithmetic sets the sticky flag only here and never clears it
				if (alu_ovf_in) begin
					status_flags_nxt[`CSSR_BIT_CLAMP] = 1'b1;
				end
			end
			default: begin
			end
		endcase
	end

	// ---------------------------------------------------------------
	// status word next value, later events take priority
	// ---------------------------------------------------------------
	always_comb begin
		status_word_nxt = status_flags_nxt;
		if (status_wr) begin
			status_word_nxt = sysreg_wdata_in[`CSSR_STATUS_W-1:0];
		end
		if (debug_return_instr_in) begin
			status_word_nxt = debug_trap_saved_status_r;
		end
		if (trap_event) begin
			status_word_nxt[`CSSR_BIT_FAULT] = 1'b1;
		end
		if (irq_take) begin
			status_word_nxt[`CSSR_BIT_IRQ_BLOCK] = 1'b1;
		end
		if (nmi_take) begin
			status_word_nxt[`CSSR_BIT_NONMASK]   = 1'b1;
			status_word_nxt[`CSSR_BIT_IRQ_BLOCK] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			status_word_r <= `CSSR_STATUS_RESET;
		end else begin
			status_word_r <= status_word_nxt;
		end
	end

	// ---------------------------------------------------------------
	// cause register
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			exception_cause_r <= 32'h00000000;
		end else if (cause_load) begin
			exception_cause_r <= event_code_in;
		end
	end

	// ---------------------------------------------------------------
	// table call save pair
	// ---------------------------------------------------------------
	// the instruction's own save outranks a write in the same cycle
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			table_call_saved_pc_r <= '0;
		end else if (table_call_instr_in) begin
			table_call_saved_pc_r <= pc_trim(next_pc_in);
		end else if (tc_pc_wr) begin
			table_call_saved_pc_r <= sysreg_wdata_in[`CSSR_PC_W-1:0];
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			table_call_saved_status_r <= '0;
		end else if (table_call_instr_in) begin
			table_call_saved_status_r <= status_word_r;
		end else if (tc_status_wr) begin
			table_call_saved_status_r <= sysreg_wdata_in[`CSSR_STATUS_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// debug access window
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			debug_window_r <= 1'b0;
		end else if (dbg_open) begin
			debug_window_r <= 1'b1;
		end else if (debug_return_instr_in) begin
			debug_window_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// debug save pair
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			debug_trap_saved_pc_r <= '0;
		end else if (trap_event) begin
			debug_trap_saved_pc_r <= pc_trim(next_pc_in);
		end else if (dbg_pc_wr) begin
			debug_trap_saved_pc_r <= sysreg_wdata_in[`CSSR_PC_W-1:0];
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			debug_trap_saved_status_r <= '0;
		end else if (trap_event) begin
			debug_trap_saved_status_r <= status_word_r;
		end else if (dbg_status_wr) begin
			debug_trap_saved_status_r <= sysreg_wdata_in[`CSSR_STATUS_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// read port, registered; unmapped or locked numbers read zero
	// ---------------------------------------------------------------
	always_comb begin
		rdata_nxt = 32'h00000000;
		unique case (sysreg_num_in)
			`CSSR_SREG_CAUSE:   rdata_nxt = exception_cause_r;
			`CSSR_SREG_STATUS:  rdata_nxt = stat_wide(status_word_r);
			`CSSR_SREG_TC_PC:   rdata_nxt = pc_wide(table_call_saved_pc_r);
			`CSSR_SREG_TC_STAT: rdata_nxt = stat_wide(table_call_saved_status_r);
			`CSSR_SREG_DBG_PC: begin
				if (dbg_acc) begin
					rdata_nxt = pc_wide(debug_trap_saved_pc_r);
				end
			end
			`CSSR_SREG_DBG_STAT: begin
				if (dbg_acc) begin
					rdata_nxt = stat_wide(debug_trap_saved_status_r);
				end
			end
			default:            rdata_nxt = 32'h00000000;
		endcase
	end

	// read data holds between reads so a late consumer still sees it
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sysreg_rdata_out <= 32'h00000000;
		end else if (sysreg_read_instr_in) begin
			sysreg_rdata_out <= rdata_nxt;
		end
	end

	// ---------------------------------------------------------------
	// acknowledge outputs
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_ack_out <= 1'b0;
		end else begin
			irq_ack_out <= irq_take;
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			nmi_ack_out <= 1'b0;
		end else begin
			nmi_ack_out <= nmi_take;
		end
	end

	// ---------------------------------------------------------------
	// saturation result
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sat_result_out <= 32'h00000000;
		end else if (alu_op_in == cssr_pkg::cssr_op_sat) begin
			sat_result_out <= sat_val;
		end
	end

	// ---------------------------------------------------------------
	// pc restore
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pc_load_out <= 1'b0;
		end else begin
			pc_load_out <= debug_return_instr_in;
		end
	end

	// a written odd value is forced even again on the way to the pc
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pc_value_out <= 32'h00000000;
		end else if (debug_return_instr_in) begin
			pc_value_out <= pc_wide(pc_trim(pc_wide(debug_trap_saved_pc_r)));
		end
	end

	// ---------------------------------------------------------------
	// status mirror
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			status_word_out <= {24'h000000, `CSSR_STATUS_RESET};
		end else begin
			status_word_out <= stat_wide(status_word_nxt);
		end
	end
endmodule : cssr_regs

// ==== sim/cssr_regs_sva.sv ====
// checker for the status word, saturation result, pc load and interrupt acknowledge
// assumes it is bound to cssr_regs and watches its ports only
`timescale 1ns/1ps
module cssr_regs_sva (
	input wire logic               ref_clk_in,
	input wire logic               reset_n_in,
	input wire logic               sysreg_write_instr_in,
	input wire logic [4:0]         sysreg_num_in,
	input wire logic [31:0]        sysreg_wdata_in,
	input wire cssr_pkg::cssr_op_t alu_op_in,
	input wire logic               alu_ovf_in,
	input wire logic               alu_ovf_positive_in,
	input wire logic               irq_req_in,
	input wire logic               exc_event_in,
	input wire logic               debug_trap_instr_in,
	input wire logic               illegal_opcode_in,
	input wire logic               debug_return_instr_in,
	input wire logic               irq_ack_out,
	input wire logic               nmi_ack_out,
	input wire logic [31:0]        sat_result_out,
	input wire logic               pc_load_out,
	input wire logic [31:0]        status_word_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);
	// ----------------------------------------
	// sequences
	// ----------------------------------------
	// trap-side events outrank a plain status write
	sequence quiet_s;
		!exc_event_in && !debug_trap_instr_in && !illegal_opcode_in && !debug_return_instr_in;
	endsequence
	sequence stat_wr_s;
		sysreg_write_instr_in && sysreg_num_in == 5'h05 ##0 quiet_s;
	endsequence
	sequence sat_ovf_s;
		alu_op_in == cssr_pkg::cssr_op_sat && alu_ovf_in && !sysreg_write_instr_in ##0 quiet_s;
	endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	status_hi_a: assert property (status_word_out[31:8] == 24'h0)
		else $error("status word upper bits not zero");
	wr_effect_a: assert property (stat_wr_s |=> status_word_out[7:0] == $past(sysreg_wdata_in[7:0]))
		else $error("written status not in effect");
	wr_hold_a: assert property (sysreg_write_instr_in && sysreg_num_in == 5'h05
		|=> !irq_ack_out && !nmi_ack_out)
		else $error("interrupt acknowledged during status write");
	irq_mask_a: assert property (irq_ack_out |-> $past(irq_req_in && !status_word_out[5]))
		else $error("maskable interrupt taken while blocked");
	nmi_mark_a: assert property (nmi_ack_out |-> status_word_out[7] && !$past(status_word_out[7]))
		else $error("nmi acknowledge without marking");
	np_block_a: assert property (status_word_out[7] |=> !irq_ack_out && !nmi_ack_out)
		else $error("nested interrupt during nmi servicing");
	sat_clamp_a: assert property (sat_ovf_s |=> sat_result_out == ($past(alu_ovf_positive_in) ?
		32'h7FFFFFFF : 32'h80000000) && status_word_out[4] && status_word_out[2])
		else $error("saturated result or flags wrong");
	sat_sticky_a: assert property (status_word_out[4] && !debug_return_instr_in
		&& !(sysreg_write_instr_in && sysreg_num_in == 5'h05) |=> status_word_out[4])
		else $error("sticky flag cleared");
	dbg_load_a: assert property (debug_return_instr_in |=> pc_load_out ##1 !pc_load_out)
		else $error("debug return gave no single pc load");
endmodule : cssr_regs_sva

// ==== sim/cssr_regs_bench.sv ====
// self-checking bench for cssr_regs
// assumes the design files and cssr_pkg are compiled first
`timescale 1ns/1ps
module cssr_regs_bench;
	logic ref_clk_in, reset_n_in, sysreg_write_instr_in, sysreg_read_instr_in;
	logic alu_carry_in, alu_ovf_in, alu_ovf_positive_in, irq_req_in, nmi_req_in;
	logic exc_event_in, table_call_instr_in, debug_trap_instr_in, illegal_opcode_in;
	logic debug_return_instr_in, irq_ack_out, nmi_ack_out, pc_load_out;
	logic [4:0]  sysreg_num_in;
	logic [31:0] sysreg_wdata_in, alu_result_in, event_code_in, next_pc_in, sysreg_rdata_out;
	logic [31:0] sat_result_out, pc_value_out, status_word_out;
	cssr_pkg::cssr_op_t alu_op_in;
	int errors, n_checks, cyc;
	cssr_regs cssr_regs_i (.*);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task step; @(posedge ref_clk_in); #1; endtask : step
	task check(string nm, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task wr(logic [4:0] n, logic [31:0] d);
		sysreg_num_in = n; sysreg_wdata_in = d; sysreg_write_instr_in = 1; step;
		sysreg_write_instr_in = 0;
	endtask : wr
	// rdata holds until the next read, so one spare cycle is harmless
	task rd(logic [4:0] n, logic [31:0] exp, string nm);
		sysreg_num_in = n; sysreg_read_instr_in = 1; step; sysreg_read_instr_in = 0; step;
		check(nm, sysreg_rdata_out, exp);
	endtask : rd
	task alu(cssr_pkg::cssr_op_t op, logic [31:0] r, logic c, logic v, logic p);
		alu_op_in = op; alu_result_in = r; alu_carry_in = c; alu_ovf_in = v;
		alu_ovf_positive_in = p; step; alu_op_in = cssr_pkg::cssr_op_none;
	endtask : alu
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		check("status reset", status_word_out, 32'h00000020);
		wr(5'h05, 32'hFFFFFF1F); check("status wr", status_word_out, 32'h0000001F);
		wr(5'h04, 32'h000000FF); rd(5'h04, 32'h0, "cause ro");
		wr(5'h10, 32'hFFFFFFFF); rd(5'h10, 32'h03FFFFFF, "tc pc");
		wr(5'h11, 32'hFFFFFFFF); rd(5'h11, 32'h000000FF, "tc stat");
		rd(5'h12, 32'h0, "dbg closed");
		rd(5'h07, 32'h0, "unmapped");
	endtask : t_regs
	task t_irq;
		irq_req_in = 1; event_code_in = 32'h00000080; step;
		check("irq ack", irq_ack_out, 1); check("id set", status_word_out[5], 1);
		step; check("irq masked", irq_ack_out, 0);
		wr(5'h05, 32'h0); check("held", irq_ack_out, 0);
		step; check("released", irq_ack_out, 1); irq_req_in = 0;
		rd(5'h04, 32'h00000080, "cause");
		wr(5'h05, 32'h0); nmi_req_in = 1; event_code_in = 32'h00000010; step;
		check("nmi ack", nmi_ack_out, 1); check("nonmask", status_word_out[7], 1);
		step; check("nmi nest", nmi_ack_out, 0); nmi_req_in = 0;
		rd(5'h04, 32'h00000010, "nmi cause");
		wr(5'h05, 32'h0);
	endtask : t_irq
	task t_alu;
		alu(cssr_pkg::cssr_op_plain, 32'h80000000, 1, 0, 0);
		check("carry sign", status_word_out, 32'h0A);
		alu(cssr_pkg::cssr_op_plain, 32'h0, 0, 1, 0);
		check("wrap zero", status_word_out, 32'h05);
		alu(cssr_pkg::cssr_op_sat, 32'h80000001, 0, 1, 1);
		check("sat pos", sat_result_out, 32'h7FFFFFFF); check("f", status_word_out, 32'h14);
		alu(cssr_pkg::cssr_op_sat, 32'h7FFFFFFF, 0, 1, 0);
		check("sat neg", sat_result_out, 32'h80000000); check("f", status_word_out, 32'h16);
		alu(cssr_pkg::cssr_op_sat, 32'h5, 0, 0, 0);
		check("sat true", sat_result_out, 32'h5); check("f", status_word_out, 32'h10);
		alu(cssr_pkg::cssr_op_plain, 32'h1, 0, 0, 0);
		check("sticky", status_word_out, 32'h10);
	endtask : t_alu
	task t_saves;
		next_pc_in = 32'hFF234566; table_call_instr_in = 1; step; table_call_instr_in = 0;
		rd(5'h10, 32'h03234566, "tc save pc"); rd(5'h11, 32'h10, "tc save stat");
		next_pc_in = 32'hFC000103; debug_trap_instr_in = 1; step; debug_trap_instr_in = 0;
		check("fault", status_word_out, 32'h50);
		rd(5'h12, 32'h00000102, "dbg pc"); rd(5'h13, 32'h10, "dbg stat");
		irq_req_in = 1; event_code_in = 32'h00000090; step; irq_req_in = 0;
		check("irq in ep", irq_ack_out, 1);
		wr(5'h13, 32'hFFFFFF03); debug_return_instr_in = 1; step; debug_return_instr_in = 0;
		check("pc load", pc_load_out, 1); check("pc", pc_value_out, 32'h102);
		check("restored", status_word_out, 32'h03);
		rd(5'h12, 32'h0, "dbg reclosed");
		exc_event_in = 1; event_code_in = 32'h00000030; step; exc_event_in = 0;
		check("exc fault", status_word_out[6], 1); rd(5'h04, 32'h30, "exc cause");
		wr(5'h12, 32'h00000456); debug_return_instr_in = 1; step; debug_return_instr_in = 0;
		check("dbg wr refused", pc_value_out, 32'h102);
		next_pc_in = 32'h00000201; illegal_opcode_in = 1; step; illegal_opcode_in = 0;
		rd(5'h12, 32'h00000200, "illegal pc");
		debug_return_instr_in = 1; step; debug_return_instr_in = 0;
		check("illegal restore", status_word_out, 32'h03);
	endtask : t_saves
	// ----------------------------------------
	// run control
	// ----------------------------------------
	task print_verdict;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		ref_clk_in = 0;
		forever #4 ref_clk_in = ~ref_clk_in;
	end
	// run is about 60 cycles, ceiling leaves wide margin
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 2000) begin
			errors++;
			print_verdict();
		end
	end
	initial begin
		{reset_n_in, sysreg_write_instr_in, sysreg_read_instr_in, alu_carry_in, alu_ovf_in} = 0;
		{alu_ovf_positive_in, irq_req_in, nmi_req_in, exc_event_in, table_call_instr_in} = 0;
		{debug_trap_instr_in, illegal_opcode_in, debug_return_instr_in} = 0;
		{sysreg_num_in, sysreg_wdata_in, alu_result_in, event_code_in, next_pc_in} = 0;
		alu_op_in = cssr_pkg::cssr_op_none;
		repeat (3) @(posedge ref_clk_in);
		#1 reset_n_in = 1;
		t_regs; t_irq; t_alu; t_saves;
		print_verdict();
	end
endmodule : cssr_regs_bench
bind cssr_regs cssr_regs_sva cssr_regs_sva_i (.*);
